// ### core/tbtc_pkg.sv
// constants, field layouts and types for the touch burst timing block
package tbtc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and sampling rate
  localparam int unsigned CLK_HZ         = 20_000_000; // clk_sys rate
  localparam int unsigned SAMP_TARGET_HZ = 1_000_000;  // wanted sample rate
  // prescale value that lands the sampling clock near the target
  localparam logic [15:0] DIV_FOR_TARGET =
    16'(CLK_HZ / (2 * SAMP_TARGET_HZ) - 1);

  ////////////////////////////////////////////////////////////////////////
  // bus and array widths
  localparam int ADDR_W  = 8;  // byte address width
  localparam int DATA_W  = 32; // register word width
  localparam int N_ELEC  = 17; // sense electrode count
  localparam int CNT_W   = 8;  // phase and transfer counter width
  localparam int DIV_W   = 16; // prescale field width

  ////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00; // start, group, count
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04; // run state, done
  localparam logic [ADDR_W-1:0] OFS_TG0  = 8'h20; // group 0 timing
  localparam logic [ADDR_W-1:0] OFS_TG1  = 8'h28; // group 1 timing
  localparam logic [ADDR_W-1:0] OFS_RES  = 8'h68; // drive resistance

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CFG_DIV_LSB    = 16; // prescale field
  localparam int CFG_CHARGE_LENGTH_LSB  = 8;  // charge_length field
  localparam int CFG_SETTLE_LENGTH_LSB  = 0;  // settle_length field
  localparam int CTRL_START_BIT = 0;  // write one to start
  localparam int CTRL_GRP_BIT   = 1;  // group to measure
  localparam int CTRL_NXF_LSB   = 8;  // transfers per burst
  localparam int STAT_BUSY_BIT  = 0;  // burst running
  localparam int STAT_CHG_BIT   = 1;  // charge phase
  localparam int STAT_SET_BIT   = 2;  // settle phase
  localparam int STAT_GRP_BIT   = 3;  // group in measurement
  localparam int STAT_DONE_BIT  = 4;  // sticky done, write one clears
  localparam int STAT_XF_LSB    = 8;  // transfers ended by a new charge phase

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DATA_W-1:0] TG_RST   = 32'h0000_0000;
  localparam logic [N_ELEC-1:0] RES_RST  = 17'h0_0000;
  localparam logic [CNT_W-1:0]  NXF_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // types
  // one touch group timing word
  typedef struct packed {
    logic [DIV_W-1:0] div;   // prescale value
    logic [CNT_W-1:0] charge_length; // charge_length in sample cycles
    logic [CNT_W-1:0] settle_length; // settle_length in sample cycles
  } tbtc_cfg_t;

  // register bus request from the master
  typedef struct packed {
    logic [ADDR_W-1:0] addr;  // byte address
    logic [DATA_W-1:0] wdata; // write data
    logic              wr;    // write strobe
    logic              rd;    // read strobe
  } tbtc_bus_t;

  // burst sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHARGE,
    ST_SETTLE
  } tbtc_state_t;

endpackage

// ### core/tbtc_prescaler.sv
// prescaler making the sampling clock and its once-per-period pulse
module tbtc_prescaler
  import tbtc_pkg::*;
#(
  parameter int W = DIV_W // prescale field width
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // control
  input  wire logic         run_i,
  input  wire logic [W-1:0] div_i,
  // sampling clock
  output logic              samp_clk_o,
  output logic              tick_o
);

  logic [W-1:0] cnt_r; // clocks since last toggle

  // half period of div+1 clocks, full period 2(div+1); stops when idle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r      <= '0;
      samp_clk_o <= 1'b0;
      tick_o     <= 1'b0;
    end else if (!run_i) begin
      cnt_r      <= '0;
      samp_clk_o <= 1'b0;
      tick_o     <= 1'b0;
    end else if (cnt_r == div_i) begin
      cnt_r      <= '0;
      samp_clk_o <= ~samp_clk_o;
      tick_o     <= samp_clk_o;   // falling edge ends a period
    end else begin
      cnt_r      <= cnt_r + 1'b1;
      tick_o     <= 1'b0;
    end
  end

endmodule

// ### core/tbtc_top.sv
// touch burst timing and electrode drive configuration block
module tbtc_top
  import tbtc_pkg::*;
#(
  parameter int NE = N_ELEC // number of sense electrodes
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // register port
  input  wire tbtc_bus_t         bus_i,
  output logic [DATA_W-1:0]      rdata_o,
  // measurement trigger from the event system
  input  wire logic              start_evt_i,
  // burst timing to the acquisition logic
  output logic                   samp_clk_o,
  output logic                   burst_o,
  output logic                   charge_o,
  output logic                   settle_o,
  output logic                   grp_o,
  output logic                   done_o,
  // electrode pad drive control
  output logic [NE-1:0]          res_drive_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  tbtc_cfg_t         cfg_r [2];   // timing word per group
  tbtc_cfg_t         cfg_act_r;   // words of the group being measured
  logic [NE-1:0]     res_r;       // drive_resistance_select bits
  logic              grp_sel_r;   // group chosen for next burst
  logic [CNT_W-1:0]  nxfer_r;     // transfers per burst, 0 means 1
  logic [CNT_W-1:0]  nxf_act_r;   // latched transfer count
  logic              grp_act_r;   // group in measurement
  logic              done_flag_r; // sticky burst complete
  tbtc_state_t       state_r;     // sequencer state
  tbtc_state_t       state_nxt;   // next sequencer state
  logic [CNT_W-1:0]  ph_cnt_r;    // sample periods in this phase
  logic [CNT_W-1:0]  xf_cnt_r;    // transfers ended by a new charge phase
  logic              tick;        // end of one sampling period
  logic              busy;        // sequencer not idle
  logic              start_take;  // start accepted this cycle
  logic              wr_ctrl;     // write to control register
  logic              wr_stat;     // write to status register
  logic              last_xf;     // final transfer of the burst
  logic [DATA_W-1:0] stat_word;   // status read value
  logic [DATA_W-1:0] rd_mux;      // read value before the flop
  logic              grp_take;    // group a start now would use
  logic [CNT_W-1:0]  nxf_take;    // transfer count a start would use
  assign busy    = (state_r != ST_IDLE);
  assign wr_ctrl = bus_i.wr && (bus_i.addr == OFS_CTRL);
  assign wr_stat = bus_i.wr && (bus_i.addr == OFS_STAT);
  // start by software bit or by event; ignored while busy
  assign start_take = !busy &&
    ((wr_ctrl && bus_i.wdata[CTRL_START_BIT]) || start_evt_i);
  assign last_xf = (xf_cnt_r + 1'b1 >= nxf_act_r);
  assign grp_take = wr_ctrl ? bus_i.wdata[CTRL_GRP_BIT] : grp_sel_r;
  assign nxf_take = wr_ctrl ? bus_i.wdata[CTRL_NXF_LSB +: CNT_W] : nxfer_r;

  ////////////////////////////////////////////////////////////////////////
  // prescaler
  // runs only during a burst, from the measured group's div
  tbtc_prescaler #(
    .W (DIV_W)
  ) u_presc (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .run_i      (busy),
    .div_i      (cfg_act_r.div),
    .samp_clk_o (samp_clk_o),
    .tick_o     (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers written by software
  // group timing words, one per group
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r[0] <= TG_RST;
      cfg_r[1] <= TG_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == OFS_TG0) begin
        cfg_r[0] <= bus_i.wdata;
      end
      if (bus_i.addr == OFS_TG1) begin
        cfg_r[1] <= bus_i.wdata;
      end
    end
  end

  // drive resistance select, upper bits dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      res_r <= RES_RST;
    end else if (bus_i.wr && (bus_i.addr == OFS_RES)) begin
      res_r <= bus_i.wdata[NE-1:0];
    end
  end

  // control fields; the start bit itself is not stored
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      grp_sel_r <= 1'b0;
      nxfer_r   <= NXF_RST;
    end else if (wr_ctrl) begin
      grp_sel_r <= bus_i.wdata[CTRL_GRP_BIT];
      nxfer_r   <= bus_i.wdata[CTRL_NXF_LSB +: CNT_W];
    end
  end

  // sticky done; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_flag_r <= 1'b0;
    end else if (state_r == ST_SETTLE && state_nxt == ST_IDLE) begin
      done_flag_r <= 1'b1;
    end else if (wr_stat && bus_i.wdata[STAT_DONE_BIT]) begin
      done_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst setup: latch the measured group's words at start
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_act_r <= TG_RST;
      grp_act_r <= 1'b0;
      nxf_act_r <= NXF_RST;
    end else if (start_take) begin
      cfg_act_r <= cfg_r[grp_take];
      grp_act_r <= grp_take;
      nxf_act_r <= (nxf_take == '0) ? CNT_W'(1) : nxf_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: charge then settle, repeated for each transfer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_take) begin
          state_nxt = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        // charge_length periods done
        if (ph_cnt_r == cfg_act_r.charge_length) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // settle_length periods done
        if (ph_cnt_r == cfg_act_r.settle_length) begin
          state_nxt = last_xf ? ST_IDLE : ST_CHARGE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // sampling periods counted within the current phase
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ph_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      ph_cnt_r <= '0;
    end else if (tick) begin
      ph_cnt_r <= ph_cnt_r + 1'b1;
    end
  end

  // transfers in this burst ended by a following charge phase
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xf_cnt_r <= '0;
    end else if (start_take) begin
      xf_cnt_r <= '0;
    end else if (state_r == ST_SETTLE && state_nxt == ST_CHARGE) begin
      xf_cnt_r <= xf_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // phase indications follow the next state, so they track state_r
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      burst_o  <= 1'b0;
      charge_o <= 1'b0;
      settle_o <= 1'b0;
      grp_o    <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      burst_o  <= (state_nxt != ST_IDLE);
      charge_o <= (state_nxt == ST_CHARGE);
      settle_o <= (state_nxt == ST_SETTLE);
      grp_o    <= start_take ? grp_take : grp_act_r;
      done_o   <= (state_r == ST_SETTLE) && (state_nxt == ST_IDLE);
    end
  end

  // resistive drive only for selected pads during the burst
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      res_drive_o <= '0;
    end else if (state_nxt != ST_IDLE) begin
      res_drive_o <= res_r;
    end else begin
      res_drive_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port
  // status word built from live state
  always_comb begin
    stat_word = '0;
    stat_word[STAT_BUSY_BIT] = busy;
    stat_word[STAT_CHG_BIT]  = (state_r == ST_CHARGE);
    stat_word[STAT_SET_BIT]  = (state_r == ST_SETTLE);
    stat_word[STAT_GRP_BIT]  = grp_act_r;
    stat_word[STAT_DONE_BIT] = done_flag_r;
    stat_word[STAT_XF_LSB +: CNT_W] = xf_cnt_r;
  end

  // address decode, unmapped reads give zero
  always_comb begin
    rd_mux = '0;
    case (bus_i.addr)
      OFS_CTRL: begin
        rd_mux[CTRL_GRP_BIT] = grp_sel_r;
        rd_mux[CTRL_NXF_LSB +: CNT_W] = nxfer_r;
      end
      OFS_STAT: rd_mux = stat_word;
      OFS_TG0:  rd_mux = cfg_r[0];
      OFS_TG1:  rd_mux = cfg_r[1];
      OFS_RES:  rd_mux[NE-1:0] = res_r;
      default:  rd_mux = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_o <= '0;
    end else if (bus_i.rd) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [DIV_W+1:0] per_cnt_r; // clocks in the current sample period
  logic [CNT_W-1:0] fe_cnt_r;  // sampling clock falls in this phase

  // period length helper, restarts on each period pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt_r <= '0;
    end else if (!busy) begin
      per_cnt_r <= '0;
    end else if (tick) begin
      per_cnt_r <= (DIV_W+2)'(1);
    end else begin
      per_cnt_r <= per_cnt_r + 1'b1;
    end
  end

  // falling edges of the sampling clock seen within a phase
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fe_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      fe_cnt_r <= '0;
    end else if ($fell(samp_clk_o)) begin
      fe_cnt_r <= fe_cnt_r + 1'b1;
    end
  end

  sequence s_leave_charge;
    state_r == ST_CHARGE && state_nxt == ST_SETTLE;
  endsequence

  sequence s_leave_settle;
    state_r == ST_SETTLE && state_nxt != ST_SETTLE;
  endsequence

  a_samp_period: assert property (
    tick |-> per_cnt_r == (DIV_W+2)'(2 * ({2'b00, cfg_act_r.div} + 1)))
    else $error("sampling period not 2(div+1) clocks");

  a_charge_len: assert property (
    s_leave_charge |-> fe_cnt_r == cfg_act_r.charge_length)
    else $error("charge phase length differs from charge_length");

  a_settle_len: assert property (
    s_leave_settle |-> fe_cnt_r == cfg_act_r.settle_length)
    else $error("settle phase length differs from settle_length");

  a_res_plain: assert property (
    1'b1 |=> (res_drive_o & ~$past(res_r)) == '0)
    else $error("resistive drive on a pad whose select bit is zero");

  a_res_idle: assert property (
    (!burst_o) [*2] |-> res_drive_o == '0)
    else $error("resistive drive outside the burst phase");

  a_res_burst: assert property (
    (burst_o && $stable(res_r)) [*2] |-> res_drive_o == res_r)
    else $error("selected pad lacks resistive drive in burst");

  a_cfg_group: assert property (start_take |=>
    cfg_act_r == (grp_act_r ? $past(cfg_r[1]) : $past(cfg_r[0])))
    else $error("burst not using the measured group timing");

endmodule

// ### verif/tbtc_elec_model.sv
// behavioural electrode side: measures the sampling clock it is fed
module tbtc_elec_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // sampling clock from the block
  input  wire logic        samp_clk,
  // measured sampling clock period in module clocks
  output logic [15:0]      period_o
);
  logic        samp_prev_r; // sampling clock one clock ago
  logic [15:0] cnt_r;       // module clocks since last rising edge

  ////////////////////////////////////////////////////////////////////////
  // period between rising edges of the sampling clock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      samp_prev_r <= 1'b0;
      cnt_r       <= 16'h0001;
      period_o    <= 16'h0000;
    end else begin
      samp_prev_r <= samp_clk;
      // rising edge seen: latch the gap, restart
      if (samp_clk && !samp_prev_r) begin
        period_o <= cnt_r;
        cnt_r    <= 16'h0001;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule

// ### verif/tbtc_top_tb.sv
// self-checking bench for the touch burst timing block
module tbtc_top_tb
  import tbtc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys;     // 20 MHz module clock
  logic              arst_n;      // async reset
  tbtc_bus_t         bus_i;       // register requests
  logic [DATA_W-1:0] rdata_o;     // register read data
  logic              start_evt_i; // event start
  logic              samp_clk_o;  // sampling clock
  logic              burst_o;     // burst phase
  logic              charge_o;    // charge phase
  logic              settle_o;    // settle phase
  logic              grp_o;       // group in measurement
  logic              done_o;      // burst finished pulse
  logic [N_ELEC-1:0] res_drive_o; // resistive drive requests
  logic [15:0]       samp_period; // period seen by the electrodes
  int                errors;      // mismatches
  int                checks_done; // comparisons made

  ////////////////////////////////////////////////////////////////////////
  // design, electrode model, clock
  tbtc_top #(.NE(N_ELEC)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus_i(bus_i),
    .rdata_o(rdata_o), .start_evt_i(start_evt_i),
    .samp_clk_o(samp_clk_o), .burst_o(burst_o), .charge_o(charge_o),
    .settle_o(settle_o), .grp_o(grp_o), .done_o(done_o),
    .res_drive_o(res_drive_o)
  );

  tbtc_elec_model elec (
    .clk_sys(clk_sys), .arst_n(arst_n), .samp_clk(samp_clk_o),
    .period_o(samp_period)
  );

  always #25 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_i.addr  <= a;
    bus_i.wdata <= d;
    bus_i.wr    <= 1'b1;
    @(posedge clk_sys);
    bus_i.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_i.addr <= a;
    bus_i.rd   <= 1'b1;
    @(posedge clk_sys);
    bus_i.rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // edge ending a phase of x sampling cycles begun at edge s after the
  // start edge; a zero phase lasts one clock, and sampling periods are
  // used up on the grid k*p+1, k >= 1, which runs on across phases
  function automatic int pend(input int s, input logic [7:0] x, input int p);
    int e;
    if (x == 8'h00) return s + 1;
    e = p + 1;
    while (e <= s) e += p;
    return e + (int'(x) - 1) * p + 1;
  endfunction

  // configure a group, start it, and time every transfer start and the burst end
  task automatic run_burst(input logic g, input logic [7:0] nxf,
      input logic [15:0] div, input logic [7:0] chl, input logic [7:0] sl,
      input logic [16:0] sel, input logic evt);
    int p, n, cs, t, k;
    logic pc;
    p = 2 * (int'(div) + 1);
    n = (nxf == 8'h00) ? 1 : int'(nxf);
    cs = 0;
    t = 0;
    k = 0;
    pc = 1'b0;
    bus_wr(g ? OFS_TG1 : OFS_TG0, {div, chl, sl});
    bus_wr(OFS_RES, {15'h0000, sel});
    bus_wr(OFS_CTRL, {16'h0000, nxf, 6'h00, g, ~evt});
    if (evt) begin
      @(posedge clk_sys);
      start_evt_i <= 1'b1;
      @(posedge clk_sys);
      start_evt_i <= 1'b0;
    end
    // first look is in the cycle right after the start edge
    for (int i = 0; i < 4000; i++) begin
      #1;
      if (burst_o) begin
        t++;
        // each transfer starts on the edge where the last settle ended
        if (charge_o && !pc) begin
          cmp(32'(t - 1), 32'(cs));
          cs = pend(pend(cs, chl, p), sl, p);
          k++;
        end
        cmp(32'(res_drive_o), 32'(sel));
        cmp(32'(grp_o), 32'(g));
      end else if (t > 0) begin
        cmp(32'(t), 32'(cs));
        cmp(32'(k), 32'(n));
        cmp(32'(done_o), 32'h1);
        cmp(32'(res_drive_o), 32'h0);
        cmp(32'(samp_period), 32'(p));
        break;
      end
      pc = charge_o;
      @(posedge clk_sys);
    end
    if (t == 0) cmp(32'(burst_o), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    bus_rd(OFS_TG0, d);
    cmp(d, TG_RST);
    bus_rd(OFS_TG1, d);
    cmp(d, TG_RST);
    bus_rd(OFS_RES, d);
    cmp(d, 32'h0000_0000);
    bus_wr(OFS_TG0, 32'h1234_5678);
    bus_wr(OFS_TG1, 32'h8765_4321);
    bus_wr(OFS_RES, 32'hffff_ffff);
    bus_wr(8'h40, 32'hffff_ffff);
    bus_rd(OFS_TG0, d);
    cmp(d, 32'h1234_5678);
    bus_rd(OFS_TG1, d);
    cmp(d, 32'h8765_4321);
    bus_rd(OFS_RES, d);
    cmp(d, 32'h0001_ffff);
    bus_rd(8'h40, d);
    cmp(d, 32'h0000_0000);
    cmp(32'(res_drive_o), 32'h0);
  endtask

  task automatic t_group0_multi();
    run_burst(1'b0, 8'h03, 16'h0001, 8'h03, 8'h02, 17'h1_0005, 1'b0);
  endtask

  task automatic t_group1_event();
    run_burst(1'b1, 8'h02, 16'h0000, 8'h02, 8'h00, 17'h0_a5a5, 1'b1);
  endtask

  task automatic t_target_rate();
    run_burst(1'b0, 8'h00, DIV_FOR_TARGET, 8'h01, 8'h01, 17'h0_0000, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    stop_test();
  end

  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    bus_i = '0;
    start_evt_i = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_group0_multi();
    t_group1_event();
    t_target_rate();
    stop_test();
  end
endmodule
